// File: uefc_top.sv
// Purpose: Extra-feature control of one UART: IR pulse select, auto send-request, tx/rx off,
//          multidrop enable, pin latching and shared modem pins, behind a Wishbone slave
// Assumes: UART core on the same clock; pins asynchronous
// Notes:   Shared upper pins carry ring, carrier, terminal-ready and set-ready in modem mode
//
// What this block does
// - Function bit picks general pins or modem pins
// - Unlatched: change interrupts, input read clears
// - Unlatched: pin returning clears pending interrupt
// - Latched: change interrupts, captures level, read clears
// - Latched: reverting pin keeps interrupt and level
// - General mode: shared-pin modem status and interrupt, terminal-ready ignored; send-clear status still seen
// - Modem mode: status readable, control drives, interrupts
// - Modem mode: upper pin registers ignored
// - Bit 7 selects quarter or 3/16 IR pulse
// - Bit 5 inverts auto send-request polarity
// - Bit 4 gives transmitter the send-request pin
// - Else modem control or flow logic drives it
// - Asserted on FIFO write, released after last bit
// - Bit 2 stops transmit after current character
// - Bit 1 stops receive, flushes shift register
// - Bit 0 selects multidrop or normal line
`timescale 1ns/100ps

`include "uefc_cfg.svh"

module uefc_top #(
  parameter int PINS = 8
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  // Wishbone classic slave
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [`UEFC_ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]             i_wb_sel,
  input  wire logic [31:0]            i_wb_dat,
  output logic      [31:0]            o_wb_dat,
  output logic                        o_wb_ack,
  output logic                        o_irq,
  // UART core side
  input  wire logic                   i_tx_fifo_write,
  input  wire logic                   i_tx_last_bit_done,
  input  wire logic                   i_flow_rts_n,
  output logic                        o_ir_quarter,
  output logic                        o_tx_allow,
  output logic                        o_rx_allow,
  output logic                        o_rx_flush,
  output logic                        o_multidrop,
  output logic                        o_modem_irq,
  output logic                        o_pin_irq,
  // Line side
  input  wire logic                   i_cts_n,
  output logic                        o_rts_n,
  input  wire logic [PINS-1:0]        i_pin,
  output logic      [PINS-1:0]        o_pin,
  output logic      [PINS-1:0]        o_pin_oe
);

  logic [7:0]      extra_r;
  logic [7:0]      pin_func_r;
  logic [PINS-1:0] pin_dir_r;
  logic [PINS-1:0] pin_out_r;
  logic [PINS-1:0] pin_inten_r;
  logic [7:0]      modem_ctrl_r;
  logic [7:0]      int_en_r;
  logic [7:0]      flow_ctrl_r;
  logic [7:0]      irq_stat_r;
  logic [7:0]      irq_mask_r;
  logic [PINS-1:0] pin_meta_r;
  logic [PINS-1:0] pin_sync_r;
  logic [PINS-1:0] pin_ref_r;
  logic [PINS-1:0] pin_pend_r;
  logic [PINS-1:0] pin_cap_r;
  logic            cts_meta_r;
  logic            cts_sync_r;
  logic [3:0]      modem_prev_r;
  logic [3:0]      modem_delta_r;
  logic            tx_active_r;
  logic            rx_off_d_r;

  logic            acc;
  logic            wr;
  logic            rd;
  logic            wr_lane;
  logic [7:0]      wdat;
  logic            modem_mode;
  logic            latch_mode;
  logic [PINS-1:0] gp_mask;
  logic [PINS-1:0] pin_is_in;
  logic [PINS-1:0] pin_change;
  logic [PINS-1:0] pin_pend_nxt;
  logic [PINS-1:0] pin_level_view;
  logic [3:0]      modem_now;
  logic [3:0]      modem_chg;
  logic            rd_pin_level;
  logic            rd_modem_stat;
  logic [7:0]      modem_stat_view;
  logic [7:0]      irq_events;
  logic [7:0]      rd_mux;
  uefc_pkg::uefc_rts_src_t rts_src;

  // One access per request; ack drops the cycle after it was given
  assign acc     = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr      = acc & i_wb_we;
  assign rd      = acc & ~i_wb_we;
  assign wr_lane = wr & i_wb_sel[0];
  assign wdat    = i_wb_dat[7:0];

  assign modem_mode = pin_func_r[`UEFC_PF_MODEM];
  assign latch_mode = pin_func_r[`UEFC_PF_LATCH];

  // Pins owned by the modem function are cut out of the general pin logic
  always_comb
  begin
    gp_mask = {PINS{1'b1}};
    if (modem_mode)
    begin
      gp_mask[`UEFC_PIN_RI]  = 1'b0;
      gp_mask[`UEFC_PIN_CD]  = 1'b0;
      gp_mask[`UEFC_PIN_DTR] = 1'b0;
      gp_mask[`UEFC_PIN_DSR] = 1'b0;
    end
  end

  assign pin_is_in     = ~pin_dir_r & pin_inten_r & gp_mask;
  assign pin_change    = pin_is_in & (pin_sync_r ^ pin_ref_r);
  assign rd_pin_level  = rd & (i_wb_adr == `UEFC_OFF_PIN_LEVEL);
  assign rd_modem_stat = rd & (i_wb_adr == `UEFC_OFF_MODEM_STAT);

  // Pins are asynchronous; two flops before anything looks at them
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      cts_meta_r <= 1'b1;
      cts_sync_r <= 1'b1;
    end
    else
    begin
      pin_meta_r <= i_pin;
      pin_sync_r <= pin_meta_r;
      cts_meta_r <= i_cts_n;
      cts_sync_r <= cts_meta_r;
    end
  end

  // Per-pin change tracking for both latch modes
  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      always_comb
      begin
        if (latch_mode)
          pin_pend_nxt[g] = pin_pend_r[g] | pin_change[g];
        else
          pin_pend_nxt[g] = pin_change[g];
        pin_level_view[g] = (latch_mode & pin_pend_r[g]) ? pin_cap_r[g]
                          : (pin_dir_r[g] ? pin_out_r[g] : pin_sync_r[g]);
      end

      always_ff @(posedge i_core_clk)
      begin
        if (i_rst)
        begin
          pin_ref_r[g]  <= 1'b0;
          pin_pend_r[g] <= 1'b0;
          pin_cap_r[g]  <= 1'b0;
        end
        else
        begin
          // Reading re-arms on the current level, so a change in the read cycle leaves no pending bit
          if (rd_pin_level)
          begin
            pin_ref_r[g]  <= pin_sync_r[g];
            pin_pend_r[g] <= 1'b0;
          end
          else
          begin
            pin_pend_r[g] <= pin_pend_nxt[g];
            if (latch_mode & pin_change[g] & ~pin_pend_r[g])
            begin
              pin_cap_r[g] <= pin_sync_r[g];
              pin_ref_r[g] <= pin_sync_r[g];
            end
          end
        end
      end
    end
  endgenerate

  // Modem inputs: cts, carrier, ring, set-ready; all active low on the pins
  assign modem_now = {~pin_sync_r[`UEFC_PIN_CD], ~pin_sync_r[`UEFC_PIN_RI],
                      ~pin_sync_r[`UEFC_PIN_DSR], ~cts_sync_r};
  assign modem_chg = (modem_now ^ modem_prev_r) & {{3{modem_mode}}, 1'b1};

  always_comb
  begin
    modem_stat_view    = {modem_now, modem_delta_r};
    modem_stat_view[2] = modem_delta_r[2];
    if (!modem_mode)
    begin
      modem_stat_view[7:5] = 3'b000;
      modem_stat_view[3:1] = 3'b000;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      // Matches the synchronisers' reset level, so no false change follows reset
      modem_prev_r  <= `UEFC_MODEM_IDLE;
      modem_delta_r <= 4'h0;
    end
    else
    begin
      modem_prev_r <= modem_now;
      // A change in the read cycle survives the clear
      if (rd_modem_stat)
        modem_delta_r <= modem_chg;
      else
        modem_delta_r <= modem_delta_r | modem_chg;
    end
  end

  // Register writes
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      extra_r      <= `UEFC_BYTE_ZERO;
      pin_func_r   <= `UEFC_BYTE_ZERO;
      pin_dir_r    <= '0;
      pin_out_r    <= '0;
      pin_inten_r  <= '0;
      modem_ctrl_r <= `UEFC_BYTE_ZERO;
      int_en_r     <= `UEFC_BYTE_ZERO;
      flow_ctrl_r  <= `UEFC_BYTE_ZERO;
      irq_mask_r   <= `UEFC_BYTE_ZERO;
    end
    else if (wr_lane)
    begin
      unique case (i_wb_adr)
        `UEFC_OFF_EXTRA:      extra_r      <= wdat & `UEFC_EX_WMASK;
        `UEFC_OFF_PIN_FUNC:   pin_func_r   <= wdat & 8'h03;
        `UEFC_OFF_PIN_DIR:    pin_dir_r    <= wdat[PINS-1:0];
        `UEFC_OFF_PIN_LEVEL:  pin_out_r    <= wdat[PINS-1:0];
        `UEFC_OFF_PIN_INTEN:  pin_inten_r  <= wdat[PINS-1:0];
        `UEFC_OFF_MODEM_CTRL: modem_ctrl_r <= wdat;
        `UEFC_OFF_INT_EN:     int_en_r     <= wdat;
        `UEFC_OFF_FLOW_CTRL:  flow_ctrl_r  <= wdat;
        `UEFC_OFF_IRQ_MASK:   irq_mask_r   <= wdat;
        default:              ;
      endcase
    end
  end

  // Sticky event status, write one to clear, set wins over clear
  always_comb
  begin
    irq_events                   = `UEFC_BYTE_ZERO;
    irq_events[`UEFC_IRQ_PIN]    = |(pin_change & ~pin_pend_r);
    irq_events[`UEFC_IRQ_MODEM]  = |modem_chg;
    irq_events[`UEFC_IRQ_TX_DONE] = i_tx_last_bit_done & tx_active_r;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      irq_stat_r <= `UEFC_BYTE_ZERO;
    else if (wr_lane && i_wb_adr == `UEFC_OFF_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~wdat) | irq_events;
    else
      irq_stat_r <= irq_stat_r | irq_events;
  end

  // Auto send-request: busy from the FIFO write until the last bit has left
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      tx_active_r <= 1'b0;
    else if (i_tx_fifo_write)
      tx_active_r <= 1'b1;
    else if (i_tx_last_bit_done)
      tx_active_r <= 1'b0;
  end

  // Flow control is expected off in auto mode; bit 4 wins if it is not
  always_comb
  begin
    if (extra_r[`UEFC_EX_TX_RTS])
      rts_src = uefc_pkg::UEFC_RTS_TX;
    else if (flow_ctrl_r[`UEFC_FC_HW_FLOW])
      rts_src = uefc_pkg::UEFC_RTS_FLOW;
    else
      rts_src = uefc_pkg::UEFC_RTS_SW;
  end

  // Line and core controls, all registered
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_rts_n      <= 1'b1;
      o_ir_quarter <= 1'b0;
      o_tx_allow   <= 1'b1;
      o_rx_allow   <= 1'b1;
      o_rx_flush   <= 1'b0;
      o_multidrop  <= 1'b0;
      rx_off_d_r   <= 1'b0;
    end
    else
    begin
      unique case (rts_src)
        uefc_pkg::UEFC_RTS_TX:   o_rts_n <= ~tx_active_r ^ extra_r[`UEFC_EX_RTS_INV];
        uefc_pkg::UEFC_RTS_FLOW: o_rts_n <= i_flow_rts_n;
        uefc_pkg::UEFC_RTS_SW:   o_rts_n <= ~modem_ctrl_r[`UEFC_MC_RTS];
      endcase
      o_ir_quarter <= extra_r[`UEFC_EX_IR_QUARTER];
      // The core checks this only between characters, so one in flight completes
      o_tx_allow   <= ~extra_r[`UEFC_EX_TX_OFF];
      o_rx_allow   <= ~extra_r[`UEFC_EX_RX_OFF];
      rx_off_d_r   <= extra_r[`UEFC_EX_RX_OFF];
      o_rx_flush   <= extra_r[`UEFC_EX_RX_OFF] & ~rx_off_d_r;
      o_multidrop  <= extra_r[`UEFC_EX_MULTIDROP];
    end
  end

  // Pin drivers; terminal-ready follows modem control only in modem mode
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_pin    <= '0;
      o_pin_oe <= '0;
    end
    else
    begin
      o_pin    <= pin_out_r & gp_mask;
      o_pin_oe <= pin_dir_r & gp_mask;
      if (modem_mode)
      begin
        o_pin[`UEFC_PIN_DTR]    <= ~modem_ctrl_r[`UEFC_MC_DTR];
        o_pin_oe[`UEFC_PIN_DTR] <= 1'b1;
      end
    end
  end

  // Read mux
  always_comb
  begin
    rd_mux = `UEFC_BYTE_ZERO;
    unique case (i_wb_adr)
      `UEFC_OFF_EXTRA:      rd_mux = extra_r;
      `UEFC_OFF_PIN_FUNC:   rd_mux = pin_func_r;
      `UEFC_OFF_PIN_DIR:    rd_mux = 8'(pin_dir_r);
      `UEFC_OFF_PIN_LEVEL:  rd_mux = 8'(pin_level_view);
      `UEFC_OFF_PIN_INTEN:  rd_mux = 8'(pin_inten_r);
      `UEFC_OFF_MODEM_CTRL: rd_mux = modem_ctrl_r;
      `UEFC_OFF_INT_EN:     rd_mux = int_en_r;
      `UEFC_OFF_MODEM_STAT: rd_mux = modem_stat_view;
      `UEFC_OFF_IRQ_STAT:   rd_mux = irq_stat_r;
      `UEFC_OFF_IRQ_MASK:   rd_mux = irq_mask_r;
      `UEFC_OFF_FLOW_CTRL:  rd_mux = flow_ctrl_r;
      default:              rd_mux = `UEFC_BYTE_ZERO;
    endcase
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `UEFC_WORD_ZERO;
    end
    else
    begin
      o_wb_ack <= acc;
      if (rd)
        o_wb_dat <= {24'h00_0000, rd_mux};
    end
  end

  // Interrupt outputs
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_irq       <= 1'b0;
      o_pin_irq   <= 1'b0;
      o_modem_irq <= 1'b0;
    end
    else
    begin
      o_irq       <= |(irq_stat_r & irq_mask_r);
      o_pin_irq   <= |pin_pend_r;
      o_modem_irq <= int_en_r[`UEFC_IE_MODEM] & (|modem_delta_r);
    end
  end

endmodule

// File: uefc_cfg.svh
// Purpose: Offsets, field positions and reset values of the extra-feature control block
// Assumes: 32-bit Wishbone data, 8-bit registers in the low byte of each word
// Notes:   Byte addresses; bits above 7 read as zero
`ifndef UEFC_CFG_SVH
`define UEFC_CFG_SVH

`define UEFC_ADR_W          6
`define UEFC_OFF_EXTRA      6'h00
`define UEFC_OFF_PIN_FUNC   6'h04
`define UEFC_OFF_PIN_DIR    6'h08
`define UEFC_OFF_PIN_LEVEL  6'h0c
`define UEFC_OFF_PIN_INTEN  6'h10
`define UEFC_OFF_MODEM_CTRL 6'h14
`define UEFC_OFF_INT_EN     6'h18
`define UEFC_OFF_MODEM_STAT 6'h1c
`define UEFC_OFF_IRQ_STAT   6'h20
`define UEFC_OFF_IRQ_MASK   6'h24
`define UEFC_OFF_FLOW_CTRL  6'h28

// Extra-feature control fields
`define UEFC_EX_IR_QUARTER  7
`define UEFC_EX_RTS_INV     5
`define UEFC_EX_TX_RTS      4
`define UEFC_EX_TX_OFF      2
`define UEFC_EX_RX_OFF      1
`define UEFC_EX_MULTIDROP   0
`define UEFC_EX_WMASK       8'hb7

// Pin function control fields
`define UEFC_PF_MODEM       1
`define UEFC_PF_LATCH       0

// Modem control / interrupt enable / flow control fields
`define UEFC_MC_DTR         0
`define UEFC_MC_RTS         1
`define UEFC_IE_MODEM       3
`define UEFC_FC_HW_FLOW     0

// Shared pin positions in modem mode
`define UEFC_PIN_RI         7
`define UEFC_PIN_CD         6
`define UEFC_PIN_DTR        5
`define UEFC_PIN_DSR        4

// Interrupt status fields
`define UEFC_IRQ_PIN        0
`define UEFC_IRQ_MODEM      1
`define UEFC_IRQ_TX_DONE    2

// Modem inputs as seen while the synchronised pins still rest at their reset level
`define UEFC_MODEM_IDLE     4'he

`define UEFC_BYTE_ZERO      8'h00
`define UEFC_WORD_ZERO      32'h0000_0000

`endif

// File: uefc_pkg.sv
// Purpose: Shared types of the extra-feature control block
// Assumes: Constants live in uefc_cfg.svh
// Notes:   Nothing here is imported; users write uefc_pkg::name
package uefc_pkg;

  typedef logic [7:0] uefc_byte_t;

  // Source currently steering the send-request pin, one-hot
  typedef enum logic [2:0] {
    UEFC_RTS_SW   = 3'b001,
    UEFC_RTS_FLOW = 3'b010,
    UEFC_RTS_TX   = 3'b100
  } uefc_rts_src_t;

endpackage

// File: uefc_line_model.sv
// Purpose: Far side of the shared pins and modem lines
// Assumes: Pins the device drives follow the device
// Notes:   Undriven pins show the level the bench sets
`timescale 1ns/100ps

module uefc_line_model (
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_drv,
  input  wire logic [7:0] i_drv_oe,
  output logic      [7:0] o_pin,
  output logic            o_cts_n
);
  // Driven bits win, so an output never reads back the far side
  assign o_pin = (i_drv & i_drv_oe) | (i_ext & ~i_drv_oe);
  // Far side never asserts clear-to-send (held high): clear-to-send changes are not exercised here
  assign o_cts_n = 1'b1;
endmodule

// File: uefc_top_sva.sv
// Purpose: Port-level checks of the extra-feature control block
// Assumes: Feature register shadowed from bus writes
// Notes:   Outputs may lag a register write by one cycle
`timescale 1ns/100ps
`include "uefc_cfg.svh"

module uefc_top_sva (
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire logic                   i_wb_cyc,
  input wire logic                   i_wb_stb,
  input wire logic                   i_wb_we,
  input wire logic [`UEFC_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0]             i_wb_sel,
  input wire logic [31:0]            i_wb_dat,
  input wire logic [31:0]            o_wb_dat,
  input wire logic                   o_wb_ack,
  input wire logic                   i_tx_fifo_write,
  input wire logic                   i_tx_last_bit_done,
  input wire logic                   o_ir_quarter,
  input wire logic                   o_rx_allow,
  input wire logic                   o_rx_flush,
  input wire logic                   o_multidrop,
  input wire logic                   o_rts_n
);
  logic [7:0] ex_r;
  logic       rd_ex_r;
  logic       req;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack && (i_wb_adr == `UEFC_OFF_EXTRA);
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      ex_r <= 8'h00;
    else if (req && i_wb_we && i_wb_sel[0])
      ex_r <= i_wb_dat[7:0] & `UEFC_EX_WMASK;
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      rd_ex_r <= 1'b0;
    else
      rd_ex_r <= req && !i_wb_we;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_ack_next;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_one;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_rd_ex;
    o_wb_ack && rd_ex_r |-> o_wb_dat == {24'h00_0000, ex_r};
  endproperty
  a_rd_ex: assert property (p_rd_ex) else $error("feature register readback wrong");
  property p_ir;
    $stable(ex_r) |-> o_ir_quarter == ex_r[`UEFC_EX_IR_QUARTER];
  endproperty
  a_ir: assert property (p_ir) else $error("pulse width select wrong");
  property p_md;
    $stable(ex_r) |-> o_multidrop == ex_r[`UEFC_EX_MULTIDROP];
  endproperty
  a_md: assert property (p_md) else $error("line mode wrong");
  property p_rx;
    $stable(ex_r) |-> o_rx_allow == !ex_r[`UEFC_EX_RX_OFF];
  endproperty
  a_rx: assert property (p_rx) else $error("receiver enable wrong");
  property p_flush_one;
    o_rx_flush |=> !o_rx_flush;
  endproperty
  a_flush_one: assert property (p_flush_one) else $error("flush pulse too long");
  property p_flush_cause;
    $rose(o_rx_flush) |-> ex_r[`UEFC_EX_RX_OFF];
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("flush without receiver off");
  property p_rts_on;
    ex_r[`UEFC_EX_TX_RTS] && i_tx_fifo_write |-> ##2 o_rts_n == ex_r[`UEFC_EX_RTS_INV];
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("send request not raised");
  property p_rts_off;
    ex_r[`UEFC_EX_TX_RTS] && i_tx_last_bit_done && !i_tx_fifo_write ##1 !i_tx_fifo_write
      |=> o_rts_n == !ex_r[`UEFC_EX_RTS_INV];
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("send request not released");
endmodule

bind uefc_top uefc_top_sva u_sva (.i_core_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_tx_fifo_write, .i_tx_last_bit_done,
  .o_ir_quarter, .o_rx_allow, .o_rx_flush, .o_multidrop, .o_rts_n);

// File: uefc_top_tb_top.sv
// Purpose: Register-level test of the extra-feature control block
// Assumes: Classic Wishbone master, byte lane 0 always selected
// Notes:   Pin changes pass a 2-flop synchroniser, so waits are padded
`timescale 1ns/100ps
`include "uefc_cfg.svh"

module uefc_top_tb_top;
  logic        clk, rst, cyc, stb, we, txw, txd, frts, cts, ack, irq;
  logic        irq_q, txa, rxa, rxf, md, mirq, pirq, rts;
  logic [5:0]  adr;
  logic [31:0] wd, rdat, rd;
  logic [7:0]  pin, po, poe, ext;
  int          miscompares, n_compared;

  uefc_top DUT (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq),
    .i_tx_fifo_write(txw), .i_tx_last_bit_done(txd), .i_flow_rts_n(frts), .o_ir_quarter(irq_q),
    .o_tx_allow(txa), .o_rx_allow(rxa), .o_rx_flush(rxf), .o_multidrop(md), .o_modem_irq(mirq),
    .o_pin_irq(pirq), .i_cts_n(cts), .o_rts_n(rts), .i_pin(pin), .o_pin(po), .o_pin_oe(poe));
  uefc_line_model u_line (.i_ext(ext), .i_drv(po), .i_drv_oe(poe), .o_pin(pin), .o_cts_n(cts));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    for (k = 0; k < 16 && ack !== 1'b1; k++)
      @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (ack !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rdm(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd & m, e);
  endtask

  task automatic pulse(input logic done);
    @(posedge clk);
    txw <= !done;
    txd <= done;
    @(posedge clk);
    txw <= 1'b0;
    txd <= 1'b0;
    wt(3);
  endtask

  task automatic pinset(input logic [7:0] v);
    @(posedge clk);
    ext <= v;
    wt(6);
  endtask

  initial
  begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    wd = 32'h0000_0000;
    txw = 1'b0;
    txd = 1'b0;
    frts = 1'b1;
    ext = 8'h00;
    miscompares = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    rdm(`UEFC_OFF_EXTRA, 32'hff, 32'h00, "extra reset");
    chk("rts reset", rts, 1'b1);
    wr(`UEFC_OFF_EXTRA, 8'hff);
    rdm(`UEFC_OFF_EXTRA, 32'hffff_ffff, 32'hb7, "extra reserved");
    wt(1);
    chk("ir quarter", irq_q, 1'b1);
    chk("tx allow", txa, 1'b0);
    chk("rx allow", rxa, 1'b0);
    chk("multidrop", md, 1'b1);
    wr(`UEFC_OFF_EXTRA, 8'h00);
    wt(2);
    chk("ir 3/16", irq_q, 1'b0);
    chk("normal line", md, 1'b0);
    chk("tx back", txa, 1'b1);
    wr(`UEFC_OFF_MODEM_CTRL, 8'h02);
    wt(3);
    chk("rts software", rts, 1'b0);
    wr(`UEFC_OFF_FLOW_CTRL, 8'h01);
    wt(3);
    chk("rts flow", rts, 1'b1);
    wr(`UEFC_OFF_FLOW_CTRL, 8'h00);
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(`UEFC_OFF_EXTRA, inv ? 8'h30 : 8'h10);
      wt(3);
      chk("rts idle", rts, !inv);
      pulse(1'b0);
      chk("rts tx", rts, inv);
      pulse(1'b1);
      chk("rts done", rts, !inv);
    end
    rdm(`UEFC_OFF_IRQ_STAT, 32'h04, 32'h04, "tx done event");
    chk("irq masked", irq, 1'b0);
    wr(`UEFC_OFF_IRQ_MASK, 8'h04);
    wt(2);
    chk("irq unmasked", irq, 1'b1);
    wr(`UEFC_OFF_IRQ_STAT, 8'h04);
    wt(2);
    chk("irq cleared", irq, 1'b0);
    rdm(6'h3c, 32'hffff_ffff, 32'h00, "unmapped");
    wr(`UEFC_OFF_EXTRA, 8'h00);
    wr(`UEFC_OFF_MODEM_CTRL, 8'h00);
    wr(`UEFC_OFF_PIN_INTEN, 8'h01);
    pinset(8'h01);
    chk("pin change", pirq, 1'b1);
    pinset(8'h00);
    chk("pin back", pirq, 1'b0);
    pinset(8'h01);
    rdm(`UEFC_OFF_PIN_LEVEL, 32'h01, 32'h01, "pin level");
    wt(2);
    chk("read clears", pirq, 1'b0);
    wr(`UEFC_OFF_PIN_FUNC, 8'h01);
    pinset(8'h00);
    chk("latched change", pirq, 1'b1);
    pinset(8'h01);
    chk("latched kept", pirq, 1'b1);
    rdm(`UEFC_OFF_PIN_LEVEL, 32'h01, 32'h00, "captured level");
    wt(2);
    chk("latched read", pirq, 1'b0);
    wr(`UEFC_OFF_PIN_FUNC, 8'h00);
    wr(`UEFC_OFF_INT_EN, 8'h08);
    wr(`UEFC_OFF_MODEM_CTRL, 8'h01);
    wt(2);
    chk("dtr ignored", poe[5], 1'b0);
    pinset(8'h41);
    chk("no modem irq", mirq, 1'b0);
    rdm(`UEFC_OFF_MODEM_STAT, 32'hee, 32'h00, "status hidden");
    wr(`UEFC_OFF_PIN_FUNC, 8'h02);
    wr(`UEFC_OFF_PIN_DIR, 8'hf0);
    wt(2);
    chk("modem oe", poe[7:4], 4'h2);
    chk("dtr driven", po[5], 1'b0);
    rdm(`UEFC_OFF_MODEM_STAT, 32'hf0, 32'h60, "status seen");
    pinset(8'h01);
    chk("modem irq", mirq, 1'b1);
    rdm(`UEFC_OFF_MODEM_STAT, 32'hf0, 32'he0, "status change");
    wt(2);
    chk("modem irq clear", mirq, 1'b0);
    end_sim();
  end
endmodule
